// ### logic/rmpu_pkg.sv
`default_nettype none
package rmpu_pkg;
    // Register map, byte addresses on the private peripheral port
    localparam int unsigned NUM_REGIONS = 8;
    localparam logic [31:0] REG_SELECT_ADDR = 32'he000ed98;
    localparam logic [5:0] OFS_SELECT = 6'h00;
    localparam logic [5:0] OFS_BASE = 6'h04;
    localparam logic [5:0] OFS_ATTR = 6'h08;
    localparam logic [5:0] OFS_LAST_BYTE = 6'h23;
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0000;

    // Base address register fields
    localparam int unsigned BASE_VALID_BIT = 4;
    localparam logic [31:0] BASE_ADDR_MASK = 32'hffff_ffe0;

    // Attribute and size register fields
    localparam int unsigned ATTR_XN_BIT = 28;
    localparam int unsigned ATTR_AP_LSB = 24;
    localparam int unsigned ATTR_TEX_LSB = 19;
    localparam int unsigned ATTR_S_BIT = 18;
    localparam int unsigned ATTR_C_BIT = 17;
    localparam int unsigned ATTR_B_BIT = 16;
    localparam int unsigned ATTR_SRD_LSB = 8;
    localparam int unsigned ATTR_SIZE_LSB = 1;
    localparam int unsigned ATTR_EN_BIT = 0;
    localparam logic [31:0] ATTR_WMASK = 32'h173f_ff3f;
    localparam logic [4:0] SIZE_MIN = 5'h04;
    localparam logic [4:0] SIZE_SUBREGION_MIN = 5'h07;

    // Access sizes on the register port
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    // Access permission codes
    localparam logic [2:0] AP_NONE = 3'h0;
    localparam logic [2:0] AP_PRIV_RW = 3'h1;
    localparam logic [2:0] AP_PRIV_RW_USR_RO = 3'h2;
    localparam logic [2:0] AP_FULL = 3'h3;
    localparam logic [2:0] AP_PRIV_RO = 3'h5;
    localparam logic [2:0] AP_RO_A = 3'h6;
    localparam logic [2:0] AP_RO_B = 3'h7;

    // Cache policies
    localparam logic [1:0] POL_NC = 2'h0;
    localparam logic [1:0] POL_WT = 2'h2;
    localparam logic [1:0] POL_WBWA = 2'h1;

    // Fault cause bit positions
    localparam int unsigned CAUSE_FETCH = 0;
    localparam int unsigned CAUSE_DATA = 1;
    localparam int unsigned CAUSE_PERM = 2;
    localparam int unsigned CAUSE_W = 3;

    typedef enum logic [1:0] {
        MT_STRONG,
        MT_DEVICE,
        MT_NORMAL,
        MT_RESERVED
    } rmpu_mem_type_e;

    typedef struct packed {
        logic sel;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rmpu_reg_req_s;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic fetch;
        logic priv;
    } rmpu_acc_s;

    typedef struct packed {
        logic fault;
        logic perm_fault;
        logic background;
        logic [2:0] region;
        rmpu_mem_type_e mem_type;
        logic shareable;
        logic [1:0] inner;
        logic [1:0] outer;
    } rmpu_res_s;
endpackage
`default_nettype wire

// ### logic/rmpu_region_match.sv
`default_nettype none
module rmpu_region_match (
    // Region settings
    input wire logic [31:0] base_i,
    input wire logic [31:0] attr_i,
    // Address under test
    input wire logic [31:0] addr_i,
    // Match results
    output logic hit_o,
    output logic blocked_o
);
    import rmpu_pkg::*;

    logic [4:0] size_code;
    logic [5:0] span_log2;
    logic [32:0] span_mask;
    logic [31:0] sub_shift;
    logic [2:0] sub_idx;
    logic in_range;
    logic sub_off;
    logic enabled;

    assign size_code = attr_i[ATTR_SIZE_LSB +: 5];
    assign span_log2 = {1'b0, size_code} + 6'h01;
    assign span_mask = ~((33'h0_0000_0001 << span_log2) - 33'h0_0000_0001);
    assign in_range = ((({1'b0, addr_i} ^ {1'b0, base_i}) & span_mask) == 33'h0_0000_0000);
    // Subregion n covers one eighth of the region, bit 0 the lowest
    assign sub_shift = addr_i >> (size_code - 5'h02);
    assign sub_idx = sub_shift[2:0];
    assign sub_off = (size_code >= SIZE_SUBREGION_MIN)
        && attr_i[ATTR_SRD_LSB + 32'(sub_idx)];
    // A disabled region never matches
    assign enabled = attr_i[ATTR_EN_BIT] && (size_code >= SIZE_MIN);
    assign hit_o = enabled && in_range && !sub_off;
    assign blocked_o = enabled && in_range && sub_off;
endmodule
`default_nettype wire

// ### logic/rmpu_core.sv
`default_nettype none
module rmpu_core (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire rmpu_pkg::rmpu_reg_req_s reg_req_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    // Access check
    input wire logic acc_valid_i,
    input wire rmpu_pkg::rmpu_acc_s acc_i,
    output logic res_valid_o,
    output rmpu_pkg::rmpu_res_s res_o,
    output logic mm_fault_o,
    // Fault cause
    input wire logic [rmpu_pkg::CAUSE_W-1:0] cause_clr_i,
    output logic [rmpu_pkg::CAUSE_W-1:0] fault_cause_o
);
    import rmpu_pkg::*;

    // Region table, one copy for fetches and data
    logic [2:0] sel_ff, nxt_sel;
    logic [31:0] base_ff [NUM_REGIONS];
    logic [31:0] attr_ff [NUM_REGIONS];
    logic [31:0] nxt_base [NUM_REGIONS];
    logic [31:0] nxt_attr [NUM_REGIONS];
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack;
    logic err_ff, nxt_err;

    logic [31:0] ofs_full;
    logic [5:0] word_ofs;
    logic in_win, is_sel, is_base, is_attr, acc_legal, wr_ok;
    logic [3:0] byte_en;
    logic [2:0] base_tgt;

    assign ofs_full = reg_req_i.addr - REG_SELECT_ADDR;
    assign in_win = (ofs_full[31:6] == 26'h0) && (ofs_full[5:0] <= OFS_LAST_BYTE);
    assign word_ofs = {ofs_full[5:2], 2'h0};
    assign is_sel = in_win && (word_ofs == OFS_SELECT);
    // Base at 0x04 and its aliases at 0x0c, 0x14, 0x1c
    assign is_base = in_win && (word_ofs != OFS_SELECT) && word_ofs[2];
    // Attribute at 0x08 and its aliases at 0x10, 0x18, 0x20
    assign is_attr = in_win && (word_ofs != OFS_SELECT) && !word_ofs[2];

    always_comb begin
        acc_legal = 1'b0;
        byte_en = 4'h0;
        unique case (reg_req_i.size)
            SZ_BYTE: begin
                acc_legal = is_attr;
                byte_en = 4'h1 << reg_req_i.addr[1:0];
            end
            SZ_HALF: begin
                acc_legal = is_attr && !reg_req_i.addr[0];
                byte_en = 4'h3 << reg_req_i.addr[1:0];
            end
            SZ_WORD: begin
                acc_legal = in_win && (reg_req_i.addr[1:0] == 2'h0);
                byte_en = 4'hf;
            end
            default: acc_legal = 1'b0;
        endcase
    end

    assign wr_ok = reg_req_i.sel && reg_req_i.write && acc_legal;
    assign base_tgt = reg_req_i.wdata[BASE_VALID_BIT] ? reg_req_i.wdata[2:0] : sel_ff;

    // Writes land at the next edge, so accesses see them in program order
    always_comb begin
        nxt_sel = sel_ff;
        nxt_base = base_ff;
        nxt_attr = attr_ff;
        if (wr_ok) begin
            if (is_sel) begin
                nxt_sel = reg_req_i.wdata[2:0];
            end else if (is_base) begin
                if (reg_req_i.wdata[BASE_VALID_BIT]) begin
                    nxt_sel = reg_req_i.wdata[2:0];
                end
                nxt_base[base_tgt] = reg_req_i.wdata & BASE_ADDR_MASK;
            end else begin
                for (int b = 0; b < 4; b++) begin
                    if (byte_en[b]) begin
                        nxt_attr[sel_ff][8*b +: 8] =
                            reg_req_i.wdata[8*b +: 8] & ATTR_WMASK[8*b +: 8];
                    end
                end
            end
        end
    end

    always_comb begin
        nxt_ack = reg_req_i.sel;
        nxt_err = reg_req_i.sel && !acc_legal;
        nxt_rdata = 32'h0000_0000;
        if (reg_req_i.sel && acc_legal && !reg_req_i.write) begin
            if (is_sel) begin
                nxt_rdata = {29'h0, sel_ff};
            end else if (is_base) begin
                nxt_rdata = base_ff[sel_ff] | {29'h0, sel_ff};
            end else begin
                nxt_rdata = attr_ff[sel_ff];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_ff <= SELECT_RESET[2:0];
            for (int r = 0; r < NUM_REGIONS; r++) begin
                base_ff[r] <= BASE_RESET;
                attr_ff[r] <= ATTR_RESET;
            end
            rdata_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            base_ff <= nxt_base;
            attr_ff <= nxt_attr;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign reg_ack_o = ack_ff;
    assign reg_err_o = err_ff;

    // Per-region match against the same table for fetch and data
    logic [NUM_REGIONS-1:0] hit_vec, blk_vec;

    for (genvar r = 0; r < NUM_REGIONS; r++) begin : g_region
        rmpu_region_match u_match (
            .base_i(base_ff[r]),
            .attr_i(attr_ff[r]),
            .addr_i(acc_i.addr),
            .hit_o(hit_vec[r]),
            .blocked_o(blk_vec[r])
        );
    end

    logic [2:0] win;
    logic [31:0] win_attr;
    logic [2:0] win_ap, win_tex;
    logic any_hit, any_blk, perm_ok;

    always_comb begin
        win = 3'h0;
        for (int r = 0; r < NUM_REGIONS; r++) begin
            if (hit_vec[r]) begin
                win = 3'(r);
            end
        end
    end

    assign any_hit = |hit_vec;
    assign any_blk = |blk_vec;
    assign win_attr = attr_ff[win];
    assign win_ap = win_attr[ATTR_AP_LSB +: 3];
    assign win_tex = win_attr[ATTR_TEX_LSB +: 3];

    always_comb begin
        perm_ok = 1'b0;
        unique case (win_ap)
            AP_NONE: perm_ok = 1'b0;
            AP_PRIV_RW: perm_ok = acc_i.priv;
            AP_PRIV_RW_USR_RO: perm_ok = acc_i.priv || !acc_i.write;
            AP_FULL: perm_ok = 1'b1;
            AP_PRIV_RO: perm_ok = acc_i.priv && !acc_i.write;
            AP_RO_A, AP_RO_B: perm_ok = !acc_i.write;
            default: perm_ok = 1'b0;
        endcase
    end

    rmpu_res_s res_ff, nxt_res;
    logic res_valid_ff, nxt_res_valid;
    logic mm_fault_ff, nxt_mm_fault;
    logic [CAUSE_W-1:0] cause_ff, nxt_cause;
    logic s_bit, c_bit, b_bit;

    assign s_bit = win_attr[ATTR_S_BIT];
    assign c_bit = win_attr[ATTR_C_BIT];
    assign b_bit = win_attr[ATTR_B_BIT];

    always_comb begin
        nxt_res = '0;
        nxt_res.region = win;
        nxt_res_valid = acc_valid_i;
        if (!any_hit) begin
            nxt_res.background = 1'b1;
            nxt_res.mem_type = MT_NORMAL;
            // Disabled subregion with nothing beneath faults outright
            nxt_res.fault = any_blk || !acc_i.priv;
        end else begin
            nxt_res.perm_fault = !perm_ok;
            nxt_res.fault = !perm_ok || (acc_i.fetch && win_attr[ATTR_XN_BIT]);
            if (win_tex[2]) begin
                nxt_res.mem_type = MT_NORMAL;
                nxt_res.outer = win_tex[1:0];
                nxt_res.inner = {c_bit, b_bit};
                nxt_res.shareable = s_bit;
            end else begin
                unique case ({win_tex[1:0], c_bit, b_bit})
                    4'b0000: begin
                        nxt_res.mem_type = MT_STRONG;
                        nxt_res.shareable = 1'b1;
                    end
                    4'b0001: begin
                        nxt_res.mem_type = MT_DEVICE;
                        nxt_res.shareable = 1'b1;
                    end
                    4'b0010, 4'b0011: begin
                        nxt_res.mem_type = MT_NORMAL;
                        nxt_res.shareable = s_bit;
                        nxt_res.inner = POL_WT;
                        nxt_res.outer = POL_WT;
                    end
                    4'b0100: begin
                        nxt_res.mem_type = MT_NORMAL;
                        nxt_res.shareable = s_bit;
                        nxt_res.inner = POL_NC;
                        nxt_res.outer = POL_NC;
                    end
                    4'b0111: begin
                        nxt_res.mem_type = MT_NORMAL;
                        nxt_res.shareable = s_bit;
                        nxt_res.inner = POL_WBWA;
                        nxt_res.outer = POL_WBWA;
                    end
                    4'b1000: begin
                        nxt_res.mem_type = MT_DEVICE;
                        nxt_res.shareable = 1'b0;
                    end
                    default: begin
                        nxt_res.mem_type = MT_RESERVED;
                        nxt_res.shareable = 1'b0;
                    end
                endcase
            end
        end
        nxt_mm_fault = acc_valid_i && nxt_res.fault;
        // New causes win over a clear in the same cycle
        nxt_cause = cause_ff & ~cause_clr_i;
        if (nxt_mm_fault) begin
            nxt_cause[CAUSE_FETCH] = nxt_cause[CAUSE_FETCH] | acc_i.fetch;
            nxt_cause[CAUSE_DATA] = nxt_cause[CAUSE_DATA] | !acc_i.fetch;
            nxt_cause[CAUSE_PERM] = nxt_cause[CAUSE_PERM] | nxt_res.perm_fault;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_ff <= '0;
            res_valid_ff <= 1'b0;
            mm_fault_ff <= 1'b0;
            cause_ff <= '0;
        end else begin
            res_ff <= nxt_res;
            res_valid_ff <= nxt_res_valid;
            mm_fault_ff <= nxt_mm_fault;
            cause_ff <= nxt_cause;
        end
    end

    assign res_o = res_ff;
    assign res_valid_o = res_valid_ff;
    assign mm_fault_o = mm_fault_ff;
    assign fault_cause_o = cause_ff;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_bg_unpriv: assert property (
        acc_valid_i && !any_hit && !acc_i.priv |=> mm_fault_o && res_o.background)
        else $error("unprivileged background access not faulted");
    chk_bg_priv: assert property (
        acc_valid_i && !any_hit && !any_blk && acc_i.priv |=> !mm_fault_o && res_valid_o)
        else $error("privileged background access faulted");
    chk_top_priority: assert property (
        acc_valid_i && hit_vec[7] |=> res_o.region == 3'h7)
        else $error("region 7 did not take precedence");
    chk_xn_fetch: assert property (
        acc_valid_i && any_hit && acc_i.fetch && win_attr[ATTR_XN_BIT] |=> mm_fault_o)
        else $error("fetch from execute-never region allowed");
    chk_ap_none: assert property (
        acc_valid_i && any_hit && win_ap == AP_NONE |=> res_o.perm_fault ##0 mm_fault_o)
        else $error("no-access region admitted an access");
    chk_sub_fault: assert property (
        acc_valid_i && !any_hit && any_blk |=> mm_fault_o)
        else $error("disabled subregion with no cover not faulted");
    chk_cause_hold: assert property (
        mm_fault_o && !$past(acc_i.fetch) && !cause_clr_i[CAUSE_DATA]
        |=> fault_cause_o[CAUSE_DATA])
        else $error("data fault cause not recorded");
    chk_valid_select: assert property (
        wr_ok && is_base && reg_req_i.wdata[BASE_VALID_BIT]
        |=> sel_ff == $past(reg_req_i.wdata[2:0]))
        else $error("valid base write did not move region select");
    chk_bad_size: assert property (
        reg_req_i.sel && !is_attr && reg_req_i.size != SZ_WORD |=> reg_err_o ##1 !reg_err_o[*1])
        else $error("non-word access to word-only register accepted");
    chk_attr_write: assert property (
        wr_ok && is_attr && reg_req_i.size == SZ_WORD && !$past(wr_ok)
        |=> attr_ff[$past(sel_ff)] == ($past(reg_req_i.wdata) & ATTR_WMASK))
        else $error("attribute write not applied to selected region");

    cov_bg_priv: cover property (acc_valid_i && !any_hit && acc_i.priv);
    cov_overlap: cover property (acc_valid_i && hit_vec[0] && hit_vec[7]);
    cov_alias_write: cover property (wr_ok && is_base && word_ofs != OFS_BASE);
    cov_perm_fault: cover property (mm_fault_o && res_o.perm_fault);
endmodule
`default_nettype wire

// ### dv/rmpu_cpu_model.sv
`default_nettype none
module rmpu_cpu_model (
    // Clock
    input wire logic sys_clk_i,
    // Register port
    output var rmpu_pkg::rmpu_reg_req_s reg_req_o,
    input wire logic [31:0] reg_rdata_i,
    input wire logic reg_ack_i,
    input wire logic reg_err_i,
    // Access port
    output var logic acc_valid_o,
    output var rmpu_pkg::rmpu_acc_s acc_o,
    input wire logic res_valid_i,
    input wire rmpu_pkg::rmpu_res_s res_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import rmpu_pkg::*;

    initial begin
        reg_req_o = '0;
        acc_valid_o = 1'b0;
        acc_o = '0;
    end

    // One register transfer at a time, strictly in issue order
    task automatic reg_op(input logic w, input logic [1:0] sz, input logic [5:0] ofs,
                          input logic [31:0] wd, output logic [31:0] rd, output logic er);
        @(posedge sys_clk_i);
        #1;
        reg_req_o = '{sel: 1'b1, write: w, size: sz, addr: REG_SELECT_ADDR + {26'h0, ofs},
                      wdata: wd};
        @(posedge sys_clk_i);
        #1;
        rd = (reg_ack_i === 1'b1) ? reg_rdata_i : 'x;
        er = (reg_ack_i === 1'b1) ? reg_err_i : 1'bx;
        // Released lines stop showing the last value
        reg_req_o.sel = 1'b0;
        reg_req_o.addr = ~reg_req_o.addr;
        reg_req_o.wdata = ~reg_req_o.wdata;
    endtask

    task automatic acc_op(input logic [31:0] a, input logic w, input logic f, input logic p,
                          output rmpu_res_s r);
        @(posedge sys_clk_i);
        #1;
        acc_valid_o = 1'b1;
        acc_o = '{addr: a, write: w, fetch: f, priv: p};
        @(posedge sys_clk_i);
        #1;
        r = (res_valid_i === 1'b1) ? res_i : 'x;
        acc_valid_o = 1'b0;
        acc_o.addr = ~a;
    endtask
endmodule
`default_nettype wire

// ### dv/rmpu_core_bench.sv
`default_nettype none
module rmpu_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rmpu_pkg::*;

    logic sys_clk, arst_n, ack, err, acc_valid, res_valid, mm_fault;
    logic [31:0] rdata;
    logic [2:0] cause_clr, cause;
    rmpu_reg_req_s reg_req;
    rmpu_acc_s acc_s;
    rmpu_res_s res;
    int miscompares = 0;
    int cmp_count = 0;

    rmpu_core i_dut (
        .sys_clk_i(sys_clk), .arst_n_i(arst_n), .reg_req_i(reg_req), .reg_rdata_o(rdata),
        .reg_ack_o(ack), .reg_err_o(err), .acc_valid_i(acc_valid), .acc_i(acc_s),
        .res_valid_o(res_valid), .res_o(res), .mm_fault_o(mm_fault),
        .cause_clr_i(cause_clr), .fault_cause_o(cause)
    );

    rmpu_cpu_model i_cpu (
        .sys_clk_i(sys_clk), .reg_req_o(reg_req), .reg_rdata_i(rdata), .reg_ack_i(ack),
        .reg_err_i(err), .acc_valid_o(acc_valid), .acc_o(acc_s), .res_valid_i(res_valid),
        .res_i(res)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] ex);
        cmp_count++;
        if (got !== ex) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, ex, got);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] fa(logic xn, logic [2:0] ap, logic [5:0] tscb,
                                       logic [7:0] subregion_disable_mask, logic [4:0] sz);
        return {3'h0, xn, 1'b0, ap, 2'h0, tscb, subregion_disable_mask, 2'h0, sz, 1'b1};
    endfunction

    function automatic logic ap_ok(logic [2:0] ap, logic p, logic w);
        case (ap)
            3'h1: return p;
            3'h2: return p | ~w;
            3'h3: return 1'b1;
            3'h5: return p & ~w;
            3'h6, 3'h7: return ~w;
            default: return 1'b0;
        endcase
    endfunction

    // Expected is {fault, perm_fault, background, region}
    task automatic acc(input logic [31:0] a, input logic w, input logic f, input logic p,
                       input logic [5:0] ex, input logic [5:0] m = 6'h3f);
        rmpu_res_s r;
        logic [5:0] s;
        i_cpu.acc_op(a, w, f, p, r);
        s = {r.fault, r.perm_fault, r.background, r.region};
        check("result", 32'(s & m), 32'(ex));
        check("mm_fault", 32'(mm_fault), 32'(ex[5]));
    endtask

    // Select, disable, base, then enable through the base/attribute pair picked by n[1:0]
    task automatic prog(input logic [2:0] n, input logic [31:0] base, input logic [31:0] at);
        logic [31:0] d;
        logic e;
        logic [5:0] bo;
        bo = 6'h04 + {1'b0, n[1:0], 3'h0};
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_SELECT, 32'(n), d, e);
        i_cpu.reg_op(1'b1, SZ_WORD, bo + 6'h04, at & ~32'h1, d, e);
        i_cpu.reg_op(1'b1, SZ_WORD, bo, base | 32'h10 | 32'(n), d, e);
        i_cpu.reg_op(1'b1, SZ_WORD, bo + 6'h04, at, d, e);
    endtask

    task automatic clr();
        @(posedge sys_clk);
        #1;
        cause_clr = 3'h7;
        @(posedge sys_clk);
        #1;
        cause_clr = 3'h0;
        check("cause_clr", 32'(cause), 32'h0);
    endtask

    task automatic t_regs();
        logic [1:0] bsz[5] = '{SZ_HALF, SZ_WORD, SZ_HALF, SZ_WORD, 2'h3};
        logic [5:0] bofs[5] = '{6'h00, 6'h0a, 6'h09, 6'h24, 6'h08};
        logic [31:0] d;
        logic e;
        i_cpu.reg_op(1'b0, SZ_WORD, OFS_SELECT, 32'h0, d, e);
        check("sel_rst", d, SELECT_RESET);
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_SELECT, 32'h3, d, e);
        i_cpu.reg_op(1'b1, SZ_HALF, 6'h0a, 32'h0302_0000, d, e);
        i_cpu.reg_op(1'b1, SZ_BYTE, OFS_ATTR, 32'h0000_0014, d, e);
        check("wr_err", 32'(e), 32'h0);
        for (int i = 0; i < 5; i++) begin
            i_cpu.reg_op(1'b1, bsz[i], bofs[i], 32'h7, d, e);
            check("refused", 32'(e), 32'h1);
        end
        i_cpu.reg_op(1'b0, SZ_WORD, OFS_SELECT, 32'h0, d, e);
        check("sel", d, 32'h3);
        i_cpu.reg_op(1'b0, SZ_WORD, OFS_ATTR, 32'h0, d, e);
        check("attr", d, 32'h0302_0014);
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_ATTR, 32'h0, d, e);
    endtask

    task automatic t_ovl();
        logic [31:0] d;
        logic e;
        prog(3'd0, 32'h2000_0000, fa(1'b0, AP_FULL, 6'h00, 8'h00, 5'd11));
        acc(32'h2000_0100, 1'b1, 1'b0, 1'b0, 6'h00);
        prog(3'd7, 32'h2000_0000, fa(1'b0, AP_NONE, 6'h00, 8'h02, 5'd10));
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_SELECT, 32'h0, d, e);
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_BASE, 32'h2000_0017, d, e);
        i_cpu.reg_op(1'b0, SZ_WORD, OFS_SELECT, 32'h0, d, e);
        check("sel_valid", d, 32'h7);
        i_cpu.reg_op(1'b0, SZ_WORD, OFS_BASE, 32'h0, d, e);
        check("base_rd", d, 32'h2000_0007);
        acc(32'h2000_0000, 1'b0, 1'b0, 1'b1, 6'h37);
        acc(32'h2000_0100, 1'b0, 1'b0, 1'b1, 6'h00);
        acc(32'h2000_0200, 1'b0, 1'b0, 1'b1, 6'h37);
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_SELECT, 32'h0, d, e);
        i_cpu.reg_op(1'b1, SZ_WORD, OFS_ATTR, 32'h0, d, e);
        acc(32'h2000_0100, 1'b0, 1'b0, 1'b1, 6'h20, 6'h20);
        acc(32'h2000_0900, 1'b0, 1'b0, 1'b1, 6'h08, 6'h28);
    endtask

    task automatic t_bkg();
        clr();
        acc(32'h6000_0000, 1'b0, 1'b0, 1'b1, 6'h08, 6'h28);
        acc(32'h6000_0000, 1'b0, 1'b0, 1'b0, 6'h28, 6'h28);
        check("cause_data", 32'(cause), 32'h2);
    endtask

    task automatic t_xn();
        // Small region keeps its subregion mask at zero
        prog(3'd1, 32'h3000_0000, fa(1'b1, AP_FULL, 6'h02, 8'h00, 5'd4));
        clr();
        acc(32'h3000_0010, 1'b0, 1'b1, 1'b0, 6'h21);
        check("cause_fetch", 32'(cause), 32'h1);
        acc(32'h3000_0010, 1'b0, 1'b0, 1'b0, 6'h01);
    endtask

    task automatic t_ap();
        logic pf;
        for (int a = 0; a < 8; a++) begin
            prog(3'd2, 32'h4000_0000, fa(1'b0, 3'(a), 6'h00, 8'h00, 5'd4));
            for (int k = 0; k < 4; k++) begin
                pf = ~ap_ok(3'(a), k[1], k[0]);
                acc(32'h4000_0004, k[0], 1'b0, k[1], {pf, pf, 4'h2});
            end
        end
    endtask

    task automatic t_tex();
        logic [5:0] key[8] = '{6'h00, 6'h01, 6'h06, 6'h08, 6'h0f, 6'h0d, 6'h2e, 6'h14};
        logic [6:0] ex[8] = '{7'h10, 7'h30, 7'h5a, 7'h40, 7'h55, 7'h60, 7'h59, 7'h20};
        logic [6:0] m, t;
        rmpu_res_s r;
        for (int i = 0; i < 8; i++) begin
            prog(3'd3, 32'h5000_0000, fa(1'b0, AP_FULL, key[i], 8'h00, 5'd4));
            i_cpu.acc_op(32'h5000_0000, 1'b0, 1'b0, 1'b1, r);
            m = (ex[i][6:5] == 2'b10) ? 7'h7f : 7'h70;
            t = {r.mem_type, r.shareable, r.inner, r.outer};
            check("type", 32'(t & m), 32'(ex[i]));
        end
    endtask

    initial begin
        arst_n = 1'b0;
        cause_clr = 3'h0;
        repeat (8) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        t_regs();
        t_ovl();
        t_bkg();
        t_xn();
        t_ap();
        t_tex();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
